// [inc/thermal_limit_monitor_defines.vh]
`ifndef THERMAL_LIMIT_MONITOR_DEFINES_VH
`define THERMAL_LIMIT_MONITOR_DEFINES_VH

// ****************************************
// Register indexes
// ****************************************
`define IDX_CONFIG 6'h01
`define IDX_UPPER 6'h02
`define IDX_LOWER 6'h03
`define IDX_CRIT 6'h04
`define IDX_TEMP 6'h05
`define IDX_MAKER 6'h06
`define IDX_PART 6'h07
`define IDX_TIMEOUT 6'h08

// ****************************************
// Configuration register fields
// ****************************************
`define CFG_HYST_HI 10
`define CFG_HYST_LO 9
`define CFG_SENSOR_SHUTDOWN 8
`define CFG_CLOCK 7
`define CFG_WLOCK 6
`define CFG_CLEAR 5
`define CFG_STS 4
`define CFG_EN 3
`define CFG_CONLY 2
`define CFG_POL 1
`define CFG_MODE 0
`define TMO_DIS_BIT 7

// ****************************************
// Reading register status bits
// ****************************************
`define RD_CRIT 15
`define RD_HIGH 14
`define RD_LOW 13

// ****************************************
// Reset values
// ****************************************
`define RESET_CFG 16'h0000
`define RESET_LIMIT 11'h000
`define RESET_TEMP 13'h0000
`define RESET_TMO 1'b0

// ****************************************
// Hysteresis in quarter degrees
// ****************************************
`define HYST_OFF 12'h000
`define HYST_1P5 12'h006
`define HYST_3 12'h00c
`define HYST_6 12'h018

// ****************************************
// Reading resolution masks
// ****************************************
`define MASK_RES0 13'h1ff8
`define MASK_RES1 13'h1ffc
`define MASK_RES2 13'h1ffe
`define MASK_RES3 13'h1fff

// ****************************************
// Bus answers and timing
// ****************************************
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define CLK_HZ 200000000
`define TIMEOUT_MS 25

`endif

// [verilog/thermal_limit_monitor_regs.v]
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "thermal_limit_monitor_defines.vh"

// Contract
// [RULE1] Limits and reading are two's complement; bits 12..2 always defined.
// [RULE2] Comparisons use bits 12..2 only; reads show full configured resolution.
// [RULE3] Reading bits 2..0 unused at current resolution read zero.
// [RULE4] Host writes bit 2 of limits zero at half-degree resolution.
// [RULE5] Limits: sign at 12, magnitude 11..2; host writes other bits zero.
// [RULE6] Above upper limit asserts alert when enabled.
// [RULE7] Below lower limit asserts alert when enabled.
// [RULE8] Window lock makes upper and lower limits read-only.
// [RULE9] Above critical asserts alert until at or below critical minus hysteresis.
// [RULE10] Critical lock makes critical limit read-only.
// [RULE11] Reading bit 15 flags critical, clears at or below critical minus hysteresis.
// [RULE12] Reading bit 14 sets above upper, clears at upper minus hysteresis.
// [RULE13] Reading bit 13 sets below lower minus hysteresis, clears at lower.
// [RULE14] Reading holds measured temperature in bits 12..0, limit encoding.
// [RULE15] Maker code register returns a fixed constant.
// [RULE16] Part code: fixed device code high byte, revision low byte.
// [RULE17] Timeout bit 7 zero enables timeout, one disables; resets zero.
// [RULE18] Timeout register bits 15..8 and 6..0 read zero, ignore writes.
// [RULE19] Timeout disable bit writable during shutdown.
// [RULE20] Either lock freezes the timeout disable bit.
// [RULE21] Hysteresis select: 00 off, 01 1.5, 10 3, 11 6 degrees.
// [RULE22] Flags re-evaluated per stored conversion; frozen during shutdown.
// [RULE23] Mode 0 comparator, 1 interrupt; clear releases pin only in interrupt mode.
// [RULE24] Alert enable zero keeps pin deasserted.
// [RULE25] Critical-only bit restricts alert to the critical condition.
// [RULE26] Lock bits stay set until power-on reset.
module thermal_limit_monitor_regs #(
    parameter ADDR_W = 8,
    parameter [15:0] MAKER_CODE = 16'h0a5a,
    parameter [7:0] PART_CODE = 8'h5a,
    parameter [7:0] REVISION = 8'h01,
    parameter TIMEOUT_CYCLES = (`CLK_HZ / 1000) * `TIMEOUT_MS
) (
    input wire aclk,
    input wire aresetn,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire conv_valid,
    input wire [12:0] conv_result,
    input wire [1:0] resolution_report,
    input wire scl_in,
    output reg alert_out,
    output reg alert_oe_n,
    output reg sensor_shutdown,
    output reg bus_timeout_disable,
    output reg bus_timeout
);

    localparam CW = $clog2(TIMEOUT_CYCLES + 1);
    localparam [15:0] CFG_RST = `RESET_CFG;

    // ****************************************
    // Functions
    // ****************************************
    function [5:0] reg_index;
        input [ADDR_W-1:0] addr;
        begin
            reg_index = addr[7:2];
        end
    endfunction

    function mapped;
        input [ADDR_W-1:0] addr;
        begin
            mapped = (addr[1:0] == 2'b00) && (reg_index(addr) >= `IDX_CONFIG)
                && (reg_index(addr) <= `IDX_TIMEOUT) && ((addr >> 8) == 0);
        end
    endfunction

    function [15:0] merge;
        input [15:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
        end
    endfunction

    function [12:0] res_mask;
        input [1:0] res;
        begin
            case (res)
                2'b00: res_mask = `MASK_RES0;
                2'b01: res_mask = `MASK_RES1;
                2'b10: res_mask = `MASK_RES2;
                default: res_mask = `MASK_RES3;
            endcase
        end
    endfunction

    // ****************************************
    // State
    // ****************************************
    reg [1:0] hyst_select;
    reg critical_limit_lock;
    reg window_limit_lock;
    reg alert_enable;
    reg critical_only_alert;
    reg alert_polarity;
    reg alert_mode;
    reg [10:0] upper_limit;
    reg [10:0] lower_limit;
    reg [10:0] critical_threshold;
    reg [12:0] temperature;
    reg flag_crit;
    reg flag_high;
    reg flag_low;
    reg int_latch;
    reg alert_asserted_flag;
    reg aw_held;
    reg w_held;
    reg [ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg scl_s1;
    reg scl_s2;
    reg scl_s3;
    reg scl_level;
    reg [CW-1:0] low_count;

    wire any_lock = critical_limit_lock | window_limit_lock;
    wire [15:0] cfg_rd = {5'h00, hyst_select, sensor_shutdown, critical_limit_lock, window_limit_lock,
        1'b0, alert_asserted_flag, alert_enable, critical_only_alert, alert_polarity, alert_mode};
    wire [15:0] upper_rd = {3'h0, upper_limit, 2'h0};
    wire [15:0] lower_rd = {3'h0, lower_limit, 2'h0};
    wire [15:0] crit_rd = {3'h0, critical_threshold, 2'h0};
    wire [15:0] temp_rd = {flag_crit, flag_high, flag_low, temperature & res_mask(resolution_report)}; // RULE3 RULE14
    wire [15:0] tmo_rd = {8'h00, bus_timeout_disable, 7'h00}; // RULE18

    // ****************************************
    // Write channel
    // ****************************************
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [5:0] widx = reg_index(awaddr_q);
    wire wmap = mapped(awaddr_q);
    reg [15:0] wold;
    always @* begin
        case (widx)
            `IDX_CONFIG: wold = cfg_rd;
            `IDX_UPPER: wold = upper_rd;
            `IDX_LOWER: wold = lower_rd;
            `IDX_CRIT: wold = crit_rd;
            `IDX_TIMEOUT: wold = tmo_rd;
            default: wold = 16'h0000;
        endcase
    end
    wire [15:0] nv = merge(wold, wdata_q, wstrb_q);
    wire clear_pulse = do_write && wmap && (widx == `IDX_CONFIG) && nv[`CFG_CLEAR] && alert_mode; // RULE23
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmap ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Control registers
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            hyst_select <= CFG_RST[`CFG_HYST_HI:`CFG_HYST_LO];
            sensor_shutdown <= CFG_RST[`CFG_SENSOR_SHUTDOWN];
            critical_limit_lock <= CFG_RST[`CFG_CLOCK];
            window_limit_lock <= CFG_RST[`CFG_WLOCK];
            alert_enable <= CFG_RST[`CFG_EN];
            critical_only_alert <= CFG_RST[`CFG_CONLY];
            alert_polarity <= CFG_RST[`CFG_POL];
            alert_mode <= CFG_RST[`CFG_MODE];
            upper_limit <= `RESET_LIMIT;
            lower_limit <= `RESET_LIMIT;
            critical_threshold <= `RESET_LIMIT;
            bus_timeout_disable <= `RESET_TMO; // RULE17
        end else if (do_write && wmap) begin
            case (widx)
                `IDX_CONFIG: begin
                    if (!any_lock) begin
                        hyst_select <= nv[`CFG_HYST_HI:`CFG_HYST_LO];
                        alert_enable <= nv[`CFG_EN];
                        alert_polarity <= nv[`CFG_POL];
                        alert_mode <= nv[`CFG_MODE];
                    end
                    // Shutdown can always be left, only entered while unlocked
                    if (!nv[`CFG_SENSOR_SHUTDOWN] || !any_lock) begin
                        sensor_shutdown <= nv[`CFG_SENSOR_SHUTDOWN];
                    end
                    critical_limit_lock <= critical_limit_lock | nv[`CFG_CLOCK]; // RULE26
                    window_limit_lock <= window_limit_lock | nv[`CFG_WLOCK]; // RULE26
                    if (!window_limit_lock) begin
                        critical_only_alert <= nv[`CFG_CONLY];
                    end
                end
                `IDX_UPPER: begin
                    if (!window_limit_lock) begin // RULE8
                        upper_limit <= nv[12:2]; // RULE5
                    end
                end
                `IDX_LOWER: begin
                    if (!window_limit_lock) begin // RULE8
                        lower_limit <= nv[12:2]; // RULE5
                    end
                end
                `IDX_CRIT: begin
                    if (!critical_limit_lock) begin // RULE10
                        critical_threshold <= nv[12:2];
                    end
                end
                `IDX_TIMEOUT: begin
                    // Not gated by shutdown
                    if (!any_lock) begin // RULE20 RULE19
                        bus_timeout_disable <= nv[`TMO_DIS_BIT]; // RULE18
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Limit comparison
    // ****************************************
    reg [11:0] hyst_q;
    always @* begin
        case (hyst_select) // RULE21
            2'b01: hyst_q = `HYST_1P5;
            2'b10: hyst_q = `HYST_3;
            2'b11: hyst_q = `HYST_6;
            default: hyst_q = `HYST_OFF;
        endcase
    end
    // Quarter-degree field only
    wire signed [11:0] t_s = {conv_result[12], conv_result[12:2]}; // RULE1 RULE2
    wire signed [11:0] hi_s = {upper_limit[10], upper_limit};
    wire signed [11:0] lo_s = {lower_limit[10], lower_limit};
    wire signed [11:0] cr_s = {critical_threshold[10], critical_threshold};
    wire signed [11:0] hi_h = hi_s - $signed(hyst_q);
    wire signed [11:0] lo_h = lo_s - $signed(hyst_q);
    wire signed [11:0] cr_h = cr_s - $signed(hyst_q);
    wire next_crit = (t_s > cr_s) ? 1'b1 : (t_s <= cr_h) ? 1'b0 : flag_crit; // RULE9 RULE11
    wire next_high = (t_s > hi_s) ? 1'b1 : (t_s <= hi_h) ? 1'b0 : flag_high; // RULE12
    wire next_low = (t_s < lo_h) ? 1'b1 : (t_s >= lo_s) ? 1'b0 : flag_low; // RULE13
    wire conv_take = conv_valid && !sensor_shutdown; // RULE22
    wire window_event = !critical_only_alert && ((next_high && !flag_high) || (next_low && !flag_low)); // RULE25
    always @(posedge aclk) begin
        if (!aresetn) begin
            temperature <= `RESET_TEMP;
            flag_crit <= 1'b0;
            flag_high <= 1'b0;
            flag_low <= 1'b0;
            int_latch <= 1'b0;
        end else begin
            if (conv_take) begin // RULE22
                temperature <= conv_result; // RULE14
                flag_crit <= next_crit;
                flag_high <= next_high;
                flag_low <= next_low;
            end
            // Set wins over clear
            if (conv_take && window_event) begin
                int_latch <= 1'b1;
            end else if (clear_pulse || !alert_mode) begin // RULE23
                int_latch <= 1'b0;
            end
        end
    end

    // ****************************************
    // Alert pin
    // ****************************************
    wire window_cond = !critical_only_alert && (flag_high || flag_low); // RULE6 RULE7 RULE25
    wire next_alert = alert_enable && !sensor_shutdown
        && (flag_crit || (alert_mode ? int_latch : window_cond)); // RULE24 RULE9 RULE23

    always @(posedge aclk) begin
        if (!aresetn) begin
            alert_asserted_flag <= 1'b0;
            alert_out <= 1'b0;
            alert_oe_n <= 1'b1;
        end else begin
            alert_asserted_flag <= next_alert;
            alert_out <= alert_polarity;
            alert_oe_n <= !next_alert;
        end
    end

    // ****************************************
    // Bus clock low timeout
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            scl_level <= 1'b1;
            low_count <= {CW{1'b0}};
            bus_timeout <= 1'b0;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            if (scl_s2 == scl_s3) begin
                scl_level <= scl_s3;
            end
            if (scl_level || bus_timeout_disable) begin // RULE17
                low_count <= {CW{1'b0}};
                bus_timeout <= 1'b0;
            end else if (low_count == TIMEOUT_CYCLES[CW-1:0] - 1'b1) begin
                bus_timeout <= 1'b1;
            end else begin
                low_count <= low_count + 1'b1;
            end
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    assign s_axi_arready = !s_axi_rvalid;
    wire [5:0] ridx = reg_index(s_axi_araddr);
    reg [15:0] rd_word;
    always @* begin
        case (ridx)
            `IDX_CONFIG: rd_word = cfg_rd;
            `IDX_UPPER: rd_word = upper_rd;
            `IDX_LOWER: rd_word = lower_rd;
            `IDX_CRIT: rd_word = crit_rd;
            `IDX_TEMP: rd_word = temp_rd;
            `IDX_MAKER: rd_word = MAKER_CODE; // RULE15
            `IDX_PART: rd_word = {PART_CODE, REVISION}; // RULE16
            `IDX_TIMEOUT: rd_word = tmo_rd;
            default: rd_word = 16'h0000;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= mapped(s_axi_araddr) ? {16'h0000, rd_word} : 32'h00000000;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // thermal_limit_monitor_regs

// [test/thermal_limit_monitor_props.sv]
`timescale 1ns/1ps
// ****************************************
// Bus and pin timing checks
// ****************************************
module thermal_limit_monitor_props #(
    parameter TIMEOUT_CYCLES = 50
) (
    input wire aclk,
    input wire aresetn,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_in,
    input wire alert_oe_n,
    input wire sensor_shutdown,
    input wire bus_timeout_disable,
    input wire bus_timeout
);
    logic [31:0] low_cnt;
    // Raw serial clock low cycles
    always @(posedge aclk) begin
        if (!aresetn || scl_in) low_cnt <= 32'h0;
        else if (low_cnt != 32'hffffffff) low_cnt <= low_cnt + 32'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    property p_wr_lat;
        s_wr_taken |=> s_wr_answer;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("b late");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("r late");
    property p_rd_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rd_hold: assert property (p_rd_hold) else $error("r drop");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("b drop");
    property p_ar_block;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_ar_block: assert property (p_ar_block) else $error("ar busy");
    property p_aw_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_aw_block: assert property (p_aw_block) else $error("aw busy");
    property p_tmo_dis;
        bus_timeout_disable && $past(bus_timeout_disable) |-> !bus_timeout;
    endproperty
    a_tmo_dis: assert property (p_tmo_dis) else $error("tmo on");
    property p_tmo_scl;
        $rose(bus_timeout) |-> low_cnt >= TIMEOUT_CYCLES;
    endproperty
    a_tmo_scl: assert property (p_tmo_scl) else $error("tmo early");
    property p_sensor_shutdown_quiet;
        sensor_shutdown && $past(sensor_shutdown) |-> alert_oe_n;
    endproperty
    a_sensor_shutdown_quiet: assert property (p_sensor_shutdown_quiet) else $error("alert in sensor_shutdown");
endmodule // thermal_limit_monitor_props

bind thermal_limit_monitor_regs thermal_limit_monitor_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES))
    u_thermal_limit_monitor_props (.*);

// [test/host_bus_model.sv]
`timescale 1ns/1ps
// ****************************************
// Host on the register bus and serial clock
// ****************************************
module host_bus_model (
    input wire aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    output logic s_axi_rready,
    output logic scl_in,
    output logic hung
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, hung} = '0;
        scl_in = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] v, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 100) hung <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        int n;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 100) hung <= 1'b1;
    endtask
    // Short 250 ns frame (two 125 ns periods), then clock held low
    task automatic scl_low;
        #1.3;
        repeat (4) begin
            scl_in = ~scl_in;
            #62.5;
        end
        scl_in = 1'b0;
    endtask
endmodule // host_bus_model

// [test/thermal_limit_monitor_regs_tb_top.sv]
`timescale 1ns/1ps
`include "thermal_limit_monitor_defines.vh"
module thermal_limit_monitor_regs_tb_top;
    typedef struct packed {logic w; logic [7:0] a; logic [15:0] v; logic [1:0] rsp; logic [15:0] e;} reg_row_t;
    typedef struct packed {logic [15:0] cfg; logic [1:0] res; logic [12:0] t; logic [15:0] e; logic oe;} conv_row_t;
    logic aclk, hung, aresetn = 1'b0, conv_valid = 1'b0;
    logic [12:0] conv_result = 13'h0000;
    logic [1:0] resolution_report = 2'h3, s_axi_bresp, s_axi_rresp, r;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, scl_in;
    logic alert_out, alert_oe_n, sensor_shutdown, bus_timeout_disable, bus_timeout;
    wire [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    wire [3:0] s_axi_wstrb = 4'hf;
    int num_errors = 0;
    int total_checks = 0;
    reg_row_t regs [10] = '{
        '{1'b1, 8'h08, 16'h1fff, `RESP_OKAY, 16'h1ffc},
        '{1'b1, 8'h0c, 16'he0a3, `RESP_OKAY, 16'h00a0},
        '{1'b1, 8'h10, 16'h0280, `RESP_OKAY, 16'h0280},
        '{1'b1, 8'h08, 16'h01e0, `RESP_OKAY, 16'h01e0},
        '{1'b0, 8'h18, 16'h0000, `RESP_OKAY, 16'h3c3c},
        '{1'b0, 8'h1c, 16'h0000, `RESP_OKAY, 16'h6602},
        '{1'b1, 8'h20, 16'hffff, `RESP_OKAY, 16'h0080},
        '{1'b1, 8'h20, 16'h0000, `RESP_OKAY, 16'h0000},
        '{1'b1, 8'h24, 16'h1234, `RESP_SLVERR, 16'h0000},
        '{1'b1, 8'h06, 16'h1234, `RESP_SLVERR, 16'h0000}};
    conv_row_t convs [18] = '{
        '{16'h0200, 2'h3, 13'h01f0, 16'h41f0, 1'b1}, '{16'h0208, 2'h3, 13'h01d0, 16'h41d0, 1'b0},
        '{16'h0208, 2'h3, 13'h01c8, 16'h01c8, 1'b1}, '{16'h020c, 2'h3, 13'h01f0, 16'h41f0, 1'b1},
        '{16'h020c, 2'h3, 13'h0290, 16'hc290, 1'b0}, '{16'h0208, 2'h3, 13'h0270, 16'hc270, 1'b0},
        '{16'h0208, 2'h0, 13'h0057, 16'h2050, 1'b0}, '{16'h0208, 2'h1, 13'h1fd7, 16'h3fd4, 1'b0},
        '{16'h0308, 2'h1, 13'h00a0, 16'h3fd4, 1'b1}, '{16'h0208, 2'h2, 13'h00a7, 16'h00a6, 1'b1},
        '{16'h0208, 2'h3, 13'h01e3, 16'h01e3, 1'b1}, '{16'h0008, 2'h3, 13'h0290, 16'hc290, 1'b0},
        '{16'h0008, 2'h3, 13'h027c, 16'h427c, 1'b0}, '{16'h0408, 2'h3, 13'h0290, 16'hc290, 1'b0},
        '{16'h0408, 2'h3, 13'h0254, 16'hc254, 1'b0}, '{16'h0608, 2'h3, 13'h0254, 16'hc254, 1'b0},
        '{16'h0608, 2'h3, 13'h0220, 16'h4220, 1'b0}, '{16'h0608, 2'h3, 13'h0180, 16'h0180, 1'b1}};
    // Identity values are arbitrary
    thermal_limit_monitor_regs #(.TIMEOUT_CYCLES(50), .MAKER_CODE(16'h3c3c), .PART_CODE(8'h66), .REVISION(8'h02))
        u_thermal_limit_monitor_regs (.*);
    host_bus_model u_host_bus_model (.*);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        u_host_bus_model.rd(a, d, r);
        check(d, {16'h0000, e});
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] v);
        u_host_bus_model.wr(a, v, r);
    endtask
    task automatic do_conv(input logic [15:0] cfg, input logic [1:0] res, input logic [12:0] t);
        wreg(8'h04, cfg);
        @(posedge aclk);
        resolution_report <= res;
        conv_result <= t;
        conv_valid <= 1'b1;
        @(posedge aclk);
        conv_valid <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask
    always @(posedge hung) begin
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(8'h04, 16'h0000);
        rchk(8'h20, 16'h0000);
        check(bus_timeout_disable, 1'b0);
        foreach (regs[i]) begin
            if (regs[i].w) u_host_bus_model.wr(regs[i].a, regs[i].v, r);
            else r = regs[i].rsp;
            check(r, regs[i].rsp);
            u_host_bus_model.rd(regs[i].a, d, r);
            check(r, regs[i].rsp);
            check(d, {16'h0000, regs[i].e});
        end
        foreach (convs[i]) begin
            do_conv(convs[i].cfg, convs[i].res, convs[i].t);
            rchk(8'h14, convs[i].e);
            check(alert_oe_n, convs[i].oe);
        end
        do_conv(16'h000b, 2'h3, 13'h01f0);
        check(alert_oe_n, 1'b0);
        check(alert_out, 1'b1);
        do_conv(16'h0009, 2'h3, 13'h01d0);
        check(alert_oe_n, 1'b0);
        wreg(8'h04, 16'h0029);
        repeat (3) @(posedge aclk);
        check(alert_oe_n, 1'b1);
        do_conv(16'h0008, 2'h3, 13'h01f0);
        wreg(8'h04, 16'h0028);
        repeat (3) @(posedge aclk);
        check(alert_oe_n, 1'b0);
        u_host_bus_model.scl_low();
        repeat (80) @(posedge aclk);
        check(bus_timeout, 1'b1);
        u_host_bus_model.scl_in = 1'b1;
        repeat (8) @(posedge aclk);
        check(bus_timeout, 1'b0);
        wreg(8'h04, 16'h0100);
        check(sensor_shutdown, 1'b1);
        wreg(8'h20, 16'h0080);
        rchk(8'h20, 16'h0080);
        check(bus_timeout_disable, 1'b1);
        u_host_bus_model.scl_low();
        repeat (80) @(posedge aclk);
        check(bus_timeout, 1'b0);
        u_host_bus_model.scl_in = 1'b1;
        wreg(8'h20, 16'h0000);
        wreg(8'h04, 16'h00c0);
        wreg(8'h08, 16'h0100);
        rchk(8'h08, 16'h01e0);
        wreg(8'h10, 16'h0100);
        rchk(8'h10, 16'h0280);
        wreg(8'h20, 16'h0080);
        rchk(8'h20, 16'h0000);
        wreg(8'h04, 16'h0000);
        rchk(8'h04, 16'h00c0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(8'h04, 16'h0000);
        wrap_up();
    end
endmodule // thermal_limit_monitor_regs_tb_top
